// file: flash_option_consts.svh
// Purpose: Constants for the flash option byte loader and decoder
// Assumes: Option bytes are read from flash one byte at a time after reset
// Notes: Bit positions, load order and timing counts
// Behaviour
// - Boot select bit 7: 1 boots application region, 0 loader region, except soft reset.
// - Bit 5 tri-states selected PWM pins while debugger halts the CPU.
// - Debugger enable bit 4 is active low: 1 disables, 0 enables.
// - Debugging with debugger enabled: hard fault sets flag only, no reset.
// - Bit 2 set makes shared pin the external reset, else input-only port bit.
// - With reset function active, a low pin resets the whole device.
// - Protection bit 1 at 0: programmer reads give FF, programming ignored.
// - Option bytes stay readable; under protection only whole-chip erase clears them.
// - Protection does not change in-application flash programming by the CPU.
// - Loader size: 111 none, 110 1KB, 101 2KB, 100 3KB, 0xx 4KB.
// - Brown-out byte bit 7 switches the brown-out detector on or off.
// - Level bits 5:4: 11 2.2V, 10 2.7V, 01 3.7V, 00 4.4V.
// - Detector on and bit 3 set: block in-app erase/program under brown-out.
// - Detector on and bit 2 set: a supply drop below threshold resets the device.
// - Watchdog bits 7:4: 1111 off, 0101 reset stopped in idle, else running.
// - After reset option bits are copied into register bits software may change.
// - Boot options byte reloads on every kind of reset.
// - Brown-out options byte reloads only on power-on reset.
// - Flash pages are 128 bytes; erase, program and read on both regions.
`ifndef FLASH_OPTION_CONSTS_SVH
`define FLASH_OPTION_CONSTS_SVH

`define OPT_IDX_BOOT 2'h0
`define OPT_IDX_LOADER 2'h1
`define OPT_IDX_BROWNOUT 2'h2
`define OPT_IDX_WATCHDOG 2'h3
`define OPT_NUM_BYTES 3'h4

`define BOOT_SEL_BIT 7
`define DBG_PWM_BIT 5
`define DBG_EN_N_BIT 4
`define RST_PIN_BIT 2
`define PROTECT_BIT 1
`define LDR_SIZE_MSB 2
`define LDR_SIZE_LSB 0
`define BOD_ON_BIT 7
`define BOD_LVL_MSB 5
`define BOD_LVL_LSB 4
`define BOD_INHIBIT_BIT 3
`define BOD_RST_BIT 2
`define WDT_MSB 7
`define WDT_LSB 4

`define WDT_OFF_CODE 4'hF
`define WDT_IDLE_STOP_CODE 4'h5
`define ERASED_BYTE 8'hFF
`define PAGE_BYTES 8'h80
`define LDR_NONE 3'h7
`define LDR_1K 3'h6
`define LDR_2K 3'h5
`define LDR_3K 3'h4
`define FLASH_ADDR_W 13
`define FLASH_TOP_KB 4'h8

// Flash read latency, 80 ns at 25 MHz
`define FLASH_READ_NS 80
`define CLK_PERIOD_NS 40
`define FLASH_READ_CYC ((`FLASH_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: flash_option_pkg.sv
// Purpose: Types for the flash option byte loader
// Assumes: Constants come from flash_option_consts.svh
// Notes: Holds the enum of load states and the decoded fields
package flash_option_pkg;

	typedef enum logic [2:0] {
		LD_IDLE = 3'b000,
		LD_ADDR = 3'b001,
		LD_WAIT = 3'b011,
		LD_STORE = 3'b010,
		LD_DONE = 3'b110
	} load_state_t;

	typedef enum logic [1:0] {
		WDT_OFF = 2'h0,
		WDT_RESET_IDLE_STOP = 2'h1,
		WDT_RESET_RUNNING = 2'h2
	} wdt_mode_t;

	typedef enum logic [1:0] {
		BOD_4V4 = 2'h0,
		BOD_3V7 = 2'h1,
		BOD_2V7 = 2'h2,
		BOD_2V2 = 2'h3
	} bod_level_t;

endpackage : flash_option_pkg

// file: option_field_decoder.sv
// Purpose: Decodes the live option register copies into block controls
// Assumes: Inputs are the register copies after load and software writes
// Notes: Pure combinational; the main file registers the results except protection and inhibit, which reach write enables directly
`include "flash_option_consts.svh"
module option_field_decoder (
	input wire logic [7:0] boot_options_byte_i,
	input wire logic [7:0] loader_size_byte_i,
	input wire logic [7:0] brownout_options_byte_i,
	input wire logic [7:0] watchdog_options_byte_i,
	output logic boot_from_app_o,
	output logic debugger_on_o,
	output logic pwm_halt_tristate_o,
	output logic reset_pin_function_o,
	output logic chip_protected_o,
	output logic [3:0] loader_kb_o,
	output logic [3:0] app_kb_o,
	output logic brownout_detect_on_o,
	output flash_option_pkg::bod_level_t brownout_level_o,
	output logic brownout_inhibit_o,
	output logic brownout_reset_on_o,
	output flash_option_pkg::wdt_mode_t watchdog_mode_o
);
	import flash_option_pkg::*;

	logic [2:0] ldr_sel;
	logic [3:0] wdt_field;

	always_comb begin
		ldr_sel = loader_size_byte_i[`LDR_SIZE_MSB:`LDR_SIZE_LSB];
		wdt_field = watchdog_options_byte_i[`WDT_MSB:`WDT_LSB];
		boot_from_app_o = boot_options_byte_i[`BOOT_SEL_BIT];
		debugger_on_o = ~boot_options_byte_i[`DBG_EN_N_BIT];
		pwm_halt_tristate_o = boot_options_byte_i[`DBG_PWM_BIT];
		reset_pin_function_o = boot_options_byte_i[`RST_PIN_BIT];
		chip_protected_o = ~boot_options_byte_i[`PROTECT_BIT];
		unique casez (ldr_sel)
			`LDR_NONE: loader_kb_o = 4'h0;
			`LDR_1K: loader_kb_o = 4'h1;
			`LDR_2K: loader_kb_o = 4'h2;
			`LDR_3K: loader_kb_o = 4'h3;
			default: loader_kb_o = 4'h4;
		endcase
		app_kb_o = `FLASH_TOP_KB - loader_kb_o;
		brownout_detect_on_o = brownout_options_byte_i[`BOD_ON_BIT];
		brownout_level_o = bod_level_t'(
			brownout_options_byte_i[`BOD_LVL_MSB:`BOD_LVL_LSB]);
		brownout_inhibit_o = brownout_options_byte_i[`BOD_INHIBIT_BIT];
		brownout_reset_on_o = brownout_options_byte_i[`BOD_RST_BIT];
		if (wdt_field == `WDT_OFF_CODE) begin
			watchdog_mode_o = WDT_OFF;
		end else if (wdt_field == `WDT_IDLE_STOP_CODE) begin
			watchdog_mode_o = WDT_RESET_IDLE_STOP;
		end else begin
			watchdog_mode_o = WDT_RESET_RUNNING;
		end
	end

endmodule : option_field_decoder

// file: flash_config_option_decoder.sv
// Purpose: Loads option bytes from flash after reset and drives decoded controls
// Assumes: Flash read port answers after a fixed latency; inputs synchronous
// Notes: Software overrides the copies through a byte write port
`include "flash_option_consts.svh"
module flash_config_option_decoder (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic por_event_i,
	input wire logic soft_reset_event_i,
	input wire logic any_reset_event_i,
	output logic [1:0] opt_rd_index_o,
	output logic opt_rd_req_o,
	input wire logic [7:0] opt_rd_data_i,
	input wire logic sw_wr_i,
	input wire logic [1:0] sw_index_i,
	input wire logic [7:0] sw_wdata_i,
	output logic [7:0] sw_rdata_o,
	output logic cpu_reset_hold_o,
	output logic boot_from_app_o,
	input wire logic debug_mode_i,
	input wire logic debug_halt_i,
	input wire logic [4:0] pwm_pin_select_i,
	output logic [4:0] pwm_tristate_o,
	input wire logic hard_fault_i,
	output logic hard_fault_flag_o,
	input wire logic hard_fault_flag_clr_i,
	input wire logic external_reset_n_i,
	output logic port_bit_in_o,
	output logic device_reset_req_o,
	output logic debugger_on_o,
	input wire logic prog_rd_i,
	input wire logic [7:0] prog_flash_data_i,
	input wire logic prog_is_option_i,
	output logic [7:0] prog_rdata_o,
	input wire logic prog_wr_i,
	input wire logic prog_chip_erase_i,
	output logic prog_wr_allow_o,
	input wire logic iap_wr_i,
	output logic iap_wr_allow_o,
	input wire logic [`FLASH_ADDR_W-1:0] flash_addr_i,
	output logic addr_in_loader_o,
	output logic [5:0] flash_page_o,
	output logic [3:0] loader_kb_o,
	output logic [3:0] app_kb_o,
	output logic brownout_detect_on_o,
	output flash_option_pkg::bod_level_t brownout_level_o,
	input wire logic supply_low_i,
	output flash_option_pkg::wdt_mode_t watchdog_mode_o
);
	import flash_option_pkg::*;

	typedef struct packed {
		load_state_t st;
		logic [1:0] idx;
		logic [1:0] wait_cnt;
		logic reload_bod;
		logic [7:0] boot_q;
		logic [7:0] ldr_q;
		logic [7:0] bod_q;
		logic [7:0] wdt_q;
		logic [7:0] sw_rdata;
		logic [7:0] prog_rdata;
		logic hard_fault_flag;
		logic [4:0] pwm_tri;
		logic pin_in;
		logic rst_req;
		logic boot_app;
		logic dbg_on;
		logic in_loader;
		logic [5:0] page;
		logic [3:0] ldr_kb;
		logic [3:0] app_kb;
		logic bod_on;
		bod_level_t bod_lvl;
		wdt_mode_t wdt_mode;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic dec_boot_app;
	logic dec_dbg_on;
	logic dec_pwm_tri;
	logic dec_rst_pin;
	logic dec_protect;
	logic [3:0] dec_ldr_kb;
	logic [3:0] dec_app_kb;
	logic dec_bod_on;
	bod_level_t dec_bod_lvl;
	logic dec_bod_inh;
	logic dec_bod_rst;
	wdt_mode_t dec_wdt;
	logic loading;
	logic bod_inhibit;

	option_field_decoder u_dec (
		.boot_options_byte_i(s_q.boot_q),
		.loader_size_byte_i(s_q.ldr_q),
		.brownout_options_byte_i(s_q.bod_q),
		.watchdog_options_byte_i(s_q.wdt_q),
		.boot_from_app_o(dec_boot_app),
		.debugger_on_o(dec_dbg_on),
		.pwm_halt_tristate_o(dec_pwm_tri),
		.reset_pin_function_o(dec_rst_pin),
		.chip_protected_o(dec_protect),
		.loader_kb_o(dec_ldr_kb),
		.app_kb_o(dec_app_kb),
		.brownout_detect_on_o(dec_bod_on),
		.brownout_level_o(dec_bod_lvl),
		.brownout_inhibit_o(dec_bod_inh),
		.brownout_reset_on_o(dec_bod_rst),
		.watchdog_mode_o(dec_wdt)
	);

	// Inhibit only counts while the detector is actually on
	assign bod_inhibit = dec_bod_on & dec_bod_inh & supply_low_i;
	assign loading = (s_q.st != LD_DONE);

	always_comb begin
		s_d = s_q;
		// Reload sequence; brown-out byte skipped unless power-on
		unique case (s_q.st)
			LD_IDLE: begin
				s_d.idx = `OPT_IDX_BOOT;
				s_d.st = LD_ADDR;
			end
			LD_ADDR: begin
				s_d.wait_cnt = 2'(`FLASH_READ_CYC);
				s_d.st = LD_WAIT;
			end
			LD_WAIT: begin
				s_d.wait_cnt = s_q.wait_cnt - 2'h1;
				if (s_q.wait_cnt == 2'h1) begin
					s_d.st = LD_STORE;
				end
			end
			LD_STORE: begin
				unique case (s_q.idx)
					`OPT_IDX_BOOT: s_d.boot_q = opt_rd_data_i;
					`OPT_IDX_LOADER: s_d.ldr_q = opt_rd_data_i;
					`OPT_IDX_BROWNOUT: s_d.bod_q = opt_rd_data_i;
					`OPT_IDX_WATCHDOG: s_d.wdt_q = opt_rd_data_i;
				endcase
				s_d.st = LD_ADDR;
				if (s_q.idx == `OPT_IDX_WATCHDOG) begin
					s_d.st = LD_DONE;
				end else if (s_q.idx == `OPT_IDX_LOADER && !s_q.reload_bod) begin
					s_d.idx = `OPT_IDX_WATCHDOG;
				end else begin
					s_d.idx = s_q.idx + 2'h1;
				end
			end
			LD_DONE: begin
				// Software overrides once loading is finished
				if (sw_wr_i) begin
					unique case (sw_index_i)
						`OPT_IDX_BOOT: s_d.boot_q = sw_wdata_i;
						`OPT_IDX_LOADER: s_d.ldr_q = sw_wdata_i;
						`OPT_IDX_BROWNOUT: s_d.bod_q = sw_wdata_i;
						`OPT_IDX_WATCHDOG: s_d.wdt_q = sw_wdata_i;
					endcase
				end
			end
		endcase
		// Any reset restarts the load; only power-on brings the brown-out byte
		if (any_reset_event_i || por_event_i) begin
			s_d.st = LD_IDLE;
			s_d.reload_bod = por_event_i;
		end
		unique case (sw_index_i)
			`OPT_IDX_BOOT: s_d.sw_rdata = s_q.boot_q;
			`OPT_IDX_LOADER: s_d.sw_rdata = s_q.ldr_q;
			`OPT_IDX_BROWNOUT: s_d.sw_rdata = s_q.bod_q;
			`OPT_IDX_WATCHDOG: s_d.sw_rdata = s_q.wdt_q;
		endcase
		// Boot choice taken from the fresh copy; a soft reset keeps the previous choice
		if (s_q.st == LD_ADDR && s_q.idx == `OPT_IDX_LOADER && !soft_reset_event_i) begin
			s_d.boot_app = dec_boot_app;
		end
		s_d.dbg_on = dec_dbg_on;
		s_d.pwm_tri = (dec_pwm_tri && debug_halt_i) ? pwm_pin_select_i : 5'h00;
		s_d.pin_in = dec_rst_pin ? 1'b1 : external_reset_n_i;
		// Hard fault reset suppressed while debugging with debugger on
		s_d.rst_req = 1'b0;
		if (!loading && dec_rst_pin && !external_reset_n_i) begin
			s_d.rst_req = 1'b1;
		end
		if (!loading && dec_bod_on && dec_bod_rst && supply_low_i) begin
			s_d.rst_req = 1'b1;
		end
		// Flag marks every hard fault; set wins over a clear in the same cycle
		if (hard_fault_i) begin
			s_d.hard_fault_flag = 1'b1;
			if (!(debug_mode_i && dec_dbg_on)) begin
				s_d.rst_req = 1'b1;
			end
		end else if (hard_fault_flag_clr_i) begin
			s_d.hard_fault_flag = 1'b0;
		end
		// Option bytes always read back; flash reads blank when protected
		if (prog_rd_i) begin
			s_d.prog_rdata = (dec_protect && !prog_is_option_i) ?
				`ERASED_BYTE : prog_flash_data_i;
		end
		// Extra bit so a full 8 KB application region never matches
		s_d.in_loader = ({1'h0, flash_addr_i[`FLASH_ADDR_W-1:10]} >= s_q.app_kb);
		s_d.page = flash_addr_i[`FLASH_ADDR_W-1:7];
		s_d.ldr_kb = dec_ldr_kb;
		s_d.app_kb = dec_app_kb;
		s_d.bod_on = dec_bod_on;
		s_d.bod_lvl = dec_bod_lvl;
		s_d.wdt_mode = dec_wdt;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.st <= LD_IDLE;
			s_q.reload_bod <= 1'b1;
			s_q.boot_q <= `ERASED_BYTE;
			s_q.ldr_q <= `ERASED_BYTE;
			s_q.bod_q <= `ERASED_BYTE;
			s_q.wdt_q <= `ERASED_BYTE;
			s_q.pin_in <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign opt_rd_index_o = s_q.idx;
	assign opt_rd_req_o = (s_q.st == LD_ADDR) || (s_q.st == LD_WAIT);
	assign sw_rdata_o = s_q.sw_rdata;
	assign cpu_reset_hold_o = loading;
	assign boot_from_app_o = s_q.boot_app;
	assign pwm_tristate_o = s_q.pwm_tri;
	assign hard_fault_flag_o = s_q.hard_fault_flag;
	assign port_bit_in_o = s_q.pin_in;
	assign device_reset_req_o = s_q.rst_req;
	assign debugger_on_o = s_q.dbg_on;
	assign prog_rdata_o = s_q.prog_rdata;
	// Protection blocks programmer writes except the whole-chip erase
	assign prog_wr_allow_o = prog_wr_i &
		(prog_chip_erase_i | (~dec_protect & ~prog_is_option_i) |
		(~dec_protect & prog_is_option_i));
	// CPU writes ignore protection; brown-out inhibit and the option load block them
	assign iap_wr_allow_o = iap_wr_i & ~bod_inhibit & ~loading;
	assign addr_in_loader_o = s_q.in_loader;
	assign flash_page_o = s_q.page;
	assign loader_kb_o = s_q.ldr_kb;
	assign app_kb_o = s_q.app_kb;
	assign brownout_detect_on_o = s_q.bod_on;
	assign brownout_level_o = s_q.bod_lvl;
	assign watchdog_mode_o = s_q.wdt_mode;

endmodule : flash_config_option_decoder

// file: flash_config_option_decoder_monitor.sv
// Purpose: Port-level checks on the option byte loader
// Assumes: Bound to every instance of the loader
// Notes: One clock domain, so default clocking and disable
module flash_config_option_decoder_monitor (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic sw_wr_i,
	input wire logic [1:0] sw_index_i,
	input wire logic [7:0] sw_wdata_i,
	input wire logic [7:0] sw_rdata_o,
	input wire logic cpu_reset_hold_o,
	input wire logic debug_mode_i,
	input wire logic debug_halt_i,
	input wire logic [4:0] pwm_pin_select_i,
	input wire logic [4:0] pwm_tristate_o,
	input wire logic hard_fault_i,
	input wire logic hard_fault_flag_o,
	input wire logic external_reset_n_i,
	input wire logic port_bit_in_o,
	input wire logic device_reset_req_o,
	input wire logic debugger_on_o,
	input wire logic prog_rd_i,
	input wire logic [7:0] prog_flash_data_i,
	input wire logic prog_is_option_i,
	input wire logic [7:0] prog_rdata_o,
	input wire logic iap_wr_allow_o,
	input wire logic supply_low_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	hold_release_a: assert property (
		$rose(rst_b_i) |-> cpu_reset_hold_o [*8] ##[6:12] !cpu_reset_hold_o)
		else $error("cpu hold not released in time");
	load_iap_a: assert property (cpu_reset_hold_o |-> !iap_wr_allow_o)
		else $error("flash write allowed during load");
	tristate_sel_a: assert property (
		$past(rst_b_i) |-> (pwm_tristate_o & ~({5{$past(debug_halt_i)}}
		& $past(pwm_pin_select_i))) == 5'h00)
		else $error("pwm tristate outside halted selected pins");
	fault_no_reset_a: assert property (
		debug_mode_i && debugger_on_o && hard_fault_i && external_reset_n_i
		&& !supply_low_i |=> !device_reset_req_o)
		else $error("hard fault reset while debugging");
	fault_flag_a: assert property (hard_fault_i |=> hard_fault_flag_o)
		else $error("hard fault flag not set");
	pin_reset_a: assert property (
		!cpu_reset_hold_o && !external_reset_n_i ##1 port_bit_in_o |-> device_reset_req_o)
		else $error("low reset pin gave no reset");
	option_read_a: assert property (
		prog_rd_i && prog_is_option_i |=> prog_rdata_o == $past(prog_flash_data_i))
		else $error("option byte read hidden");
	sw_copy_a: assert property (
		sw_wr_i && !cpu_reset_hold_o ##1 sw_index_i == $past(sw_index_i)
		|=> sw_rdata_o == $past(sw_wdata_i, 2))
		else $error("software write not in copy");
endmodule : flash_config_option_decoder_monitor

bind flash_config_option_decoder flash_config_option_decoder_monitor mon (.*);

// file: flash_config_option_decoder_tb.sv
// Purpose: Self-checking bench for the option byte loader
// Assumes: Option bytes answer one cycle after the index shows
// Notes: Random images from a fixed seed plus corner code tables
`include "flash_option_consts.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %0h got %0h", n, e, s); end end
module flash_config_option_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_option_pkg::*;
	logic clk_sys_i = 1'h0, rst_b_i = 1'h0, por_event_i = 1'h0, soft_reset_event_i = 1'h0;
	logic any_reset_event_i = 1'h0, sw_wr_i = 1'h0, debug_mode_i = 1'h0, debug_halt_i = 1'h0;
	logic hard_fault_i = 1'h0, hard_fault_flag_clr_i = 1'h0, external_reset_n_i = 1'h1;
	logic prog_rd_i = 1'h0, prog_is_option_i = 1'h0, prog_wr_i = 1'h0, prog_chip_erase_i = 1'h0;
	logic iap_wr_i = 1'h1, supply_low_i = 1'h0, boot_q;
	logic [1:0] sw_index_i = 2'h0, opt_rd_index_o;
	logic [4:0] pwm_pin_select_i = 5'h00, pwm_tristate_o;
	logic [7:0] opt_rd_data_i = 8'h00, sw_wdata_i = 8'h00, prog_flash_data_i = 8'h00;
	logic [`FLASH_ADDR_W-1:0] flash_addr_i = {`FLASH_ADDR_W{1'h0}};
	logic opt_rd_req_o, cpu_reset_hold_o, boot_from_app_o, hard_fault_flag_o, port_bit_in_o;
	logic device_reset_req_o, debugger_on_o, prog_wr_allow_o, iap_wr_allow_o, addr_in_loader_o;
	logic brownout_detect_on_o;
	logic [7:0] sw_rdata_o, prog_rdata_o, mem [4], exp_b [4];
	logic [5:0] flash_page_o;
	logic [3:0] loader_kb_o, app_kb_o;
	logic [3:0] wc [8] = '{4'hF, 4'h5, 4'h0, 4'hE, 4'h4, 4'h6, 4'hD, 4'h7};
	bod_level_t brownout_level_o;
	bod_level_t lv [4] = '{BOD_4V4, BOD_3V7, BOD_2V7, BOD_2V2};
	wdt_mode_t watchdog_mode_o;
	int n_fail = 0, checked = 0, cyc = 0;

	flash_config_option_decoder uut (.*);

	always #20 clk_sys_i = ~clk_sys_i;

	// Flash model; a released data bus toggles so stale bytes never pass
	always @(posedge clk_sys_i) begin
		opt_rd_data_i <= #1 opt_rd_req_o ? mem[opt_rd_index_o] : ~opt_rd_data_i;
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic check_all();
		logic [7:0] b0, b2, d;
		logic [3:0] ld;
		wdt_mode_t we;
		b0 = exp_b[0];
		b2 = exp_b[2];
		d = 8'($urandom);
		ld = exp_b[1][2] ? {1'h0, 3'h7 - exp_b[1][2:0]} : 4'h4;
		we = exp_b[3][7:4] == 4'hF ? WDT_OFF : WDT_RESET_RUNNING;
		if (exp_b[3][7:4] == 4'h5) we = WDT_RESET_IDLE_STOP;
		`CHK("boot", boot_q, boot_from_app_o)
		`CHK("dbg", ~b0[4], debugger_on_o)
		`CHK("ldr", ld, loader_kb_o)
		`CHK("app", 4'h8 - ld, app_kb_o)
		`CHK("bod", b2[7], brownout_detect_on_o)
		`CHK("lvl", lv[b2[5:4]], brownout_level_o)
		`CHK("wdt", we, watchdog_mode_o)
		for (int i = 0; i < 4; i++) begin
			sw_index_i = 2'(i);
			step(1);
			`CHK("copy", exp_b[i], sw_rdata_o)
		end
		prog_rd_i = 1'h1;
		prog_wr_i = 1'h1;
		prog_flash_data_i = d;
		prog_is_option_i = d[0];
		prog_chip_erase_i = d[1];
		supply_low_i = 1'h1;
		iap_wr_i = d[5];
		step(1);
		`CHK("pwr", b0[1] | d[1], prog_wr_allow_o)
		`CHK("prd", (b0[1] | d[0]) ? d : 8'hFF, prog_rdata_o)
		`CHK("iap", d[5] & ~(b2[7] & b2[3]), iap_wr_allow_o)
		`CHK("bor", b2[7] & b2[2], device_reset_req_o)
		prog_rd_i = 1'h0;
		prog_wr_i = 1'h0;
		prog_chip_erase_i = 1'h0;
		supply_low_i = 1'h0;
		external_reset_n_i = 1'h0;
		iap_wr_i = 1'h1;
		step(1);
		`CHK("iap0", 1'h1, iap_wr_allow_o)
		`CHK("pin", b0[2], port_bit_in_o)
		`CHK("prst", b0[2], device_reset_req_o)
		external_reset_n_i = 1'h1;
		debug_halt_i = 1'h1;
		debug_mode_i = d[2];
		pwm_pin_select_i = d[7:3];
		hard_fault_i = 1'h1;
		flash_addr_i = {d[4:0], d};
		step(1);
		`CHK("pwm", b0[5] ? d[7:3] : 5'h00, pwm_tristate_o)
		`CHK("flag", 1'h1, hard_fault_flag_o)
		`CHK("hrst", ~(d[2] & ~b0[4]), device_reset_req_o)
		`CHK("page", flash_addr_i[12:7], flash_page_o)
		`CHK("inldr", {1'h0, flash_addr_i[12:10]} >= 4'h8 - ld, addr_in_loader_o)
		debug_halt_i = 1'h0;
		hard_fault_i = 1'h0;
		hard_fault_flag_clr_i = 1'h1;
		step(1);
		`CHK("clr", 1'h0, hard_fault_flag_o)
		hard_fault_flag_clr_i = 1'h0;
	endtask : check_all

	// Kind: 0 no event (load after rst_b_i), 1 power-on, 2 other reset, 3 software reset
	task automatic reload(input int kind);
		int k;
		k = 0;
		por_event_i = (kind == 1);
		any_reset_event_i = (kind > 1);
		soft_reset_event_i = (kind == 3);
		step(1);
		por_event_i = 1'h0;
		any_reset_event_i = 1'h0;
		while (cpu_reset_hold_o !== 1'h0 && k < 40) begin
			step(1);
			k++;
		end
		soft_reset_event_i = 1'h0;
		`CHK("load", 1'h1, k > 8 && k < 40)
		for (int i = 0; i < 4; i++) if (kind < 2 || i != 2) exp_b[i] = mem[i];
		if (kind != 3) boot_q = mem[0][7];
		step(2);
		check_all();
	endtask : reload

	task automatic sw_write(input logic [1:0] idx, input logic [7:0] v);
		sw_index_i = idx;
		sw_wdata_i = v;
		sw_wr_i = 1'h1;
		step(1);
		sw_wr_i = 1'h0;
		step(2);
		// Boot choice only follows a reload, not a software write
		exp_b[idx] = v;
		check_all();
	endtask : sw_write

	initial begin
		void'($urandom(84));
		for (int i = 0; i < 4; i++) mem[i] = 8'($urandom);
		step(6);
		rst_b_i = 1'h1;
		reload(0);
		for (int i = 0; i < 8; i++) begin
			mem[0] = 8'($urandom);
			mem[1] = {5'($urandom), 3'(i)};
			mem[2] = {2'($urandom), 2'(i), 4'($urandom)};
			mem[3] = {wc[i], 4'($urandom)};
			reload(1);
		end
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 4; j++) mem[j] = 8'($urandom);
			reload(2);
		end
		// Soft reset must keep the earlier boot choice
		mem[0] = exp_b[0] ^ 8'h80;
		reload(3);
		for (int i = 0; i < 8; i++) sw_write(2'(i), 8'($urandom));
		rst_b_i = 1'h0;
		step(2);
		rst_b_i = 1'h1;
		reload(0);
		wrap_up();
	end
endmodule : flash_config_option_decoder_tb
